//--- core/iswc_pkg.sv
// Constants for the interrupt, power-down and watchdog control block.
`default_nettype none
package iswc_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [13:0] STATUS_ADDR = 14'h0003;
    localparam logic [13:0] IRQ_CTRL_ADDR = 14'h000b;
    localparam logic [13:0] PFLAG1_ADDR = 14'h000c;
    localparam logic [13:0] PFLAG2_ADDR = 14'h000d;
    localparam logic [13:0] OPTION_ADDR = 14'h0081;
    localparam logic [13:0] PEN1_ADDR = 14'h008c;
    localparam logic [13:0] PEN2_ADDR = 14'h008d;
    localparam logic [13:0] CONFIG_ADDR = 14'h2007;

    // Interrupt control register fields.
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
    localparam int T0IE_BIT = 5;
    localparam int EXTIE_BIT = 4;
    localparam int PORTB_CHANGE_ENABLE_BIT = 3;
    localparam int T0IF_BIT = 2;
    localparam int EXTIF_BIT = 1;
    localparam int PORTB_CHANGE_FLAG_BIT = 0;

    // Status fields.
    localparam int TO_N_BIT = 4;
    localparam int PD_N_BIT = 3;

    // Option register fields.
    localparam int EDGE_SEL_BIT = 6;
    localparam int PSA_BIT = 3;
    localparam int PS_LSB = 0;
    localparam int PS_W = 3;

    // Configuration word fields.
    localparam int WDT_FUSE_BIT = 2;

    // Reset values.
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] CONFIG_RST = 8'hff;
    localparam logic [7:0] PFLAG_RST = 8'h00;
    localparam logic [7:0] PEN_RST = 8'h00;

    // Interrupt vector and instruction-cycle shape.
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [1:0] LAST_Q_PHASE = 2'h3;
endpackage : iswc_pkg
`default_nettype wire

//--- core/iswc_core.sv
// Interrupt request, power-down and watchdog control for the 8-bit core.
`default_nettype none
module iswc_core #(
    parameter int          WDT_BASE_W       = 8,
    parameter logic [15:0] PERIPH_WAKE_MASK = 16'hffff
) (
    // Clock and reset.
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    // Register port.
    input  wire logic [iswc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [iswc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [iswc_pkg::DATA_W-1:0] reg_rdata,
    // Pins.
    input  wire logic                        ext_irq_pin,
    input  wire logic [3:0]                  portb_high_pins,
    input  wire logic                        master_reset_pin_n,
    input  wire logic                        watchdog_osc_clk,
    // Same-clock event sources.
    input  wire logic                        timer_zero_overflow,
    input  wire logic [15:0]                 periph_event,
    // Core instruction events.
    input  wire logic                        irq_return_instr,
    input  wire logic                        watchdog_kick_instr,
    input  wire logic                        sleep_instr,
    // Core controls.
    output logic                             vector_take,
    output logic      [12:0]                 vector_addr,
    output logic                             wake_pulse,
    output logic                             power_down,
    output logic                             device_reset
);
    // Refuse counter widths that the timeout compare cannot serve.
    if (WDT_BASE_W < 2 || WDT_BASE_W > 24) begin : g_bad_wdt_width
        $error("WDT_BASE_W must lie between 2 and 24.");
    end

    // Prescaler terminal count for a 2^ps ratio.
    function automatic logic [7:0] ratio_mask(input logic [2:0] ps);
        ratio_mask = 8'((9'h001 << ps) - 9'h001);
    endfunction : ratio_mask

    // Registered state.
    logic [7:0]  irq_ctrl_reg;
    logic [7:0]  option_reg;
    logic [7:0]  config_reg;
    logic        config_locked_reg;
    logic [15:0] pflag_reg;
    logic [15:0] pen_reg;
    logic        to_n_reg;
    logic        pd_n_reg;
    logic [7:0]  rdata_reg;
    logic [1:0]  q_phase_reg;
    logic        vector_reg;
    logic        wake_reg;
    logic        sleep_reg;
    logic        reset_out_reg;
    logic [7:0]  prescale_reg;
    logic [WDT_BASE_W-1:0] wdt_base_reg;

    // Synchronisers and edge history.
    logic [1:0] ext_sync_reg;
    logic       ext_prev_reg;
    logic [3:0] portb_meta_reg;
    logic [3:0] portb_sync_reg;
    logic [3:0] portb_prev_reg;
    logic [1:0] master_reset_pin_sync_reg;
    logic [1:0] wdt_sync_reg;
    logic       wdt_prev_reg;
    logic [1:0] prime_cnt_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_sync_reg   <= 2'h0;
            ext_prev_reg   <= 1'b0;
            portb_meta_reg <= 4'h0;
            portb_sync_reg <= 4'h0;
            portb_prev_reg <= 4'h0;
            master_reset_pin_sync_reg  <= 2'h3;
            wdt_sync_reg   <= 2'h0;
            wdt_prev_reg   <= 1'b0;
            prime_cnt_reg  <= 2'h0;
        end else begin
            ext_sync_reg   <= {ext_sync_reg[0], ext_irq_pin};
            ext_prev_reg   <= ext_sync_reg[1];
            portb_meta_reg <= portb_high_pins;
            portb_sync_reg <= portb_meta_reg;
            portb_prev_reg <= portb_sync_reg;
            master_reset_pin_sync_reg  <= {master_reset_pin_sync_reg[0], master_reset_pin_n};
            wdt_sync_reg   <= {wdt_sync_reg[0], watchdog_osc_clk};
            wdt_prev_reg   <= wdt_sync_reg[1];
            if (prime_cnt_reg != 2'h3) begin
                prime_cnt_reg <= prime_cnt_reg + 2'h1;
            end
        end
    end

    // Event detection.
    logic ext_edge;
    logic portb_change;
    logic wdt_tick;
    logic master_reset_pin_active;
    logic edge_rising;
    logic hist_ready;

    // Edge history is trusted only once both stages and the history flop
    // hold real pin samples, so an idle-high pin gives no false edge.
    assign hist_ready   = (prime_cnt_reg == 2'h3);
    assign edge_rising  = option_reg[iswc_pkg::EDGE_SEL_BIT];
    assign ext_edge     = hist_ready & (edge_rising ?
                          (ext_sync_reg[1] & ~ext_prev_reg) :
                          (~ext_sync_reg[1] & ext_prev_reg));
    assign portb_change = hist_ready
                          & (|(portb_sync_reg ^ portb_prev_reg));
    assign wdt_tick     = hist_ready & wdt_sync_reg[1] & ~wdt_prev_reg;
    assign master_reset_pin_active  = ~master_reset_pin_sync_reg[1];

    // Request combining.
    logic core_req;
    logic periph_req;
    logic any_req;
    logic wake_req;
    logic global_irq_enable;

    assign global_irq_enable        = irq_ctrl_reg[iswc_pkg::GIE_BIT];
    assign core_req   = (irq_ctrl_reg[iswc_pkg::T0IF_BIT]
                         & irq_ctrl_reg[iswc_pkg::T0IE_BIT])
                      | (irq_ctrl_reg[iswc_pkg::EXTIF_BIT]
                         & irq_ctrl_reg[iswc_pkg::EXTIE_BIT])
                      | (irq_ctrl_reg[iswc_pkg::PORTB_CHANGE_FLAG_BIT]
                         & irq_ctrl_reg[iswc_pkg::PORTB_CHANGE_ENABLE_BIT]);
    assign periph_req = irq_ctrl_reg[iswc_pkg::PERIPHERAL_GROUP_ENABLE_BIT]
                        & (|(pflag_reg & pen_reg));
    assign any_req    = core_req | periph_req;
    // Every core source may wake the core; a peripheral source only where PERIPH_WAKE_MASK is set.
    assign wake_req   = core_req
                      | (irq_ctrl_reg[iswc_pkg::PERIPHERAL_GROUP_ENABLE_BIT]
                         & (|(pflag_reg & pen_reg & PERIPH_WAKE_MASK)));

    // Instruction-cycle phase and vector decision.
    logic q_last;
    logic take_now;

    assign q_last   = (q_phase_reg == iswc_pkg::LAST_Q_PHASE);
    assign take_now = q_last & global_irq_enable & any_req & ~sleep_reg
                      & ~vector_reg & ~wake_reg;

    // Watchdog decisions.
    logic wdt_enabled;
    logic psa_wdt;
    logic prescale_wrap;
    logic wdt_timeout;
    logic sleep_accept;
    logic wdt_clear;
    logic [2:0] ps_sel;

    assign wdt_enabled   = config_reg[iswc_pkg::WDT_FUSE_BIT];
    assign psa_wdt       = option_reg[iswc_pkg::PSA_BIT];
    assign ps_sel        = option_reg[iswc_pkg::PS_LSB +: iswc_pkg::PS_W];
    assign prescale_wrap = ~psa_wdt | (prescale_reg == ratio_mask(ps_sel));
    assign wdt_timeout   = wdt_enabled & wdt_tick & prescale_wrap
                           & (&wdt_base_reg);
    // A request already pending turns the sleep into a no-op.
    assign sleep_accept  = sleep_instr & ~sleep_reg & ~any_req;
    assign wdt_clear     = watchdog_kick_instr | sleep_accept;

    // A watchdog timeout while running or the reset pin reboots the core.
    logic soft_reset;
    assign soft_reset = (wdt_timeout & ~sleep_reg) | master_reset_pin_active;

    logic wr_ctrl;
    logic wr_pf1;
    logic wr_pf2;
    assign wr_ctrl = reg_wr & (reg_addr == iswc_pkg::IRQ_CTRL_ADDR);
    assign wr_pf1  = reg_wr & (reg_addr == iswc_pkg::PFLAG1_ADDR);
    assign wr_pf2  = reg_wr & (reg_addr == iswc_pkg::PFLAG2_ADDR);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q_phase_reg <= 2'h0;
        end else begin
            q_phase_reg <= q_phase_reg + 2'h1;
        end
    end

    // Interrupt control register.
    logic [7:0] ctrl_next;
    always_comb begin
        ctrl_next = wr_ctrl ? reg_wdata : irq_ctrl_reg;
        // Hardware sets win over a software write in the same cycle.
        if (timer_zero_overflow) begin
            ctrl_next[iswc_pkg::T0IF_BIT] = 1'b1;
        end
        if (ext_edge) begin
            ctrl_next[iswc_pkg::EXTIF_BIT] = 1'b1;
        end
        if (portb_change) begin
            ctrl_next[iswc_pkg::PORTB_CHANGE_FLAG_BIT] = 1'b1;
        end
        if (irq_return_instr) begin
            ctrl_next[iswc_pkg::GIE_BIT] = 1'b1;
        end
        if (take_now) begin
            ctrl_next[iswc_pkg::GIE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_reset) begin
            irq_ctrl_reg <= iswc_pkg::IRQ_CTRL_RST;
        end else begin
            irq_ctrl_reg <= ctrl_next;
        end
    end

    // Peripheral flag and enable registers.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_reset) begin
            pflag_reg <= {iswc_pkg::PFLAG_RST, iswc_pkg::PFLAG_RST};
        end else begin
            pflag_reg <= {(wr_pf2 ? reg_wdata : pflag_reg[15:8]),
                          (wr_pf1 ? reg_wdata : pflag_reg[7:0])}
                         | periph_event;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_reset) begin
            pen_reg <= {iswc_pkg::PEN_RST, iswc_pkg::PEN_RST};
        end else if (reg_wr && reg_addr == iswc_pkg::PEN1_ADDR) begin
            pen_reg[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == iswc_pkg::PEN2_ADDR) begin
            pen_reg[15:8] <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_reset) begin
            option_reg <= iswc_pkg::OPTION_RST;
        end else if (reg_wr && reg_addr == iswc_pkg::OPTION_ADDR) begin
            option_reg <= reg_wdata;
        end
    end

    // The fuse word takes one write per power-up and then locks.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            config_reg        <= iswc_pkg::CONFIG_RST;
            config_locked_reg <= 1'b0;
        end else if (reg_wr && reg_addr == iswc_pkg::CONFIG_ADDR
                     && !config_locked_reg) begin
            config_reg        <= reg_wdata;
            config_locked_reg <= 1'b1;
        end
    end

    // Timeout and power-down status bits.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            to_n_reg <= 1'b1;
            pd_n_reg <= 1'b1;
        end else if (wdt_timeout) begin
            to_n_reg <= 1'b0;
            pd_n_reg <= sleep_reg ? pd_n_reg : 1'b1;
        end else if (sleep_accept || watchdog_kick_instr) begin
            to_n_reg <= 1'b1;
            pd_n_reg <= ~sleep_accept;
        end
    end

    // Watchdog prescaler and base counter.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wdt_enabled) begin
            prescale_reg <= 8'h00;
            wdt_base_reg <= '0;
        end else if (wdt_clear) begin
            // Only the counts are cleared; the assignment stays.
            if (psa_wdt) begin
                prescale_reg <= 8'h00;
            end
            wdt_base_reg <= '0;
        end else if (wdt_tick) begin
            if (psa_wdt) begin
                prescale_reg <= prescale_wrap ? 8'h00 : prescale_reg + 8'h01;
            end
            if (prescale_wrap) begin
                wdt_base_reg <= wdt_base_reg + WDT_BASE_W'(1);
            end
        end
    end

    // Power-down state.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || master_reset_pin_active) begin
            sleep_reg <= 1'b0;
            wake_reg  <= 1'b0;
        end else if (sleep_reg) begin
            if (wake_req || wdt_timeout) begin
                sleep_reg <= 1'b0;
                wake_reg  <= 1'b1;
            end
        end else begin
            sleep_reg <= sleep_accept;
            wake_reg  <= 1'b0;
        end
    end

    // Vector take: the core pushes only its return address.
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_reset) begin
            vector_reg <= 1'b0;
        end else begin
            vector_reg <= take_now;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reset_out_reg <= 1'b0;
        end else begin
            reset_out_reg <= soft_reset;
        end
    end

    // Register read port, data one cycle after the strobe.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            iswc_pkg::STATUS_ADDR: begin
                rd_mux[iswc_pkg::TO_N_BIT] = to_n_reg;
                rd_mux[iswc_pkg::PD_N_BIT] = pd_n_reg;
            end
            iswc_pkg::IRQ_CTRL_ADDR: rd_mux = irq_ctrl_reg;
            iswc_pkg::PFLAG1_ADDR:   rd_mux = pflag_reg[7:0];
            iswc_pkg::PFLAG2_ADDR:   rd_mux = pflag_reg[15:8];
            iswc_pkg::OPTION_ADDR:   rd_mux = option_reg;
            iswc_pkg::PEN1_ADDR:     rd_mux = pen_reg[7:0];
            iswc_pkg::PEN2_ADDR:     rd_mux = pen_reg[15:8];
            iswc_pkg::CONFIG_ADDR:   rd_mux = config_reg;
            default:                 rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign vector_take  = vector_reg;
    assign vector_addr  = iswc_pkg::IRQ_VECTOR;
    assign wake_pulse   = wake_reg;
    assign power_down   = sleep_reg;
    assign device_reset = reset_out_reg;
endmodule : iswc_core
`default_nettype wire

//--- testbench/iswc_properties.sv
// Port-level temporal checks for the interrupt, sleep and watchdog block.
`default_nettype none
module iswc_properties (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Register port.
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Pins and instruction events.
    input wire logic        master_reset_pin_n,
    input wire logic        sleep_instr,
    // Core controls.
    input wire logic        vector_take,
    input wire logic [12:0] vector_addr,
    input wire logic        wake_pulse,
    input wire logic        power_down,
    input wire logic        device_reset
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_VEC_ADDR: assert property (
        vector_take |-> vector_addr == 13'h0004 && !wake_pulse)
        else $error("vector address wrong or vector beside a wake pulse");
    AST_VEC_GAP: assert property (vector_take |=> !vector_take [*3])
        else $error("vector taken off the instruction-cycle boundary");
    AST_NO_VEC_ASLEEP: assert property (
        power_down && $past(power_down) |-> !vector_take)
        else $error("vector taken while powered down");
    AST_SLEEP_ENTRY: assert property (
        $rose(power_down) |-> $past(sleep_instr))
        else $error("power down entered without a sleep instruction");
    AST_WAKE_EXIT: assert property (
        wake_pulse |-> !power_down && $past(power_down))
        else $error("wake pulse without leaving power down");
    AST_RST_PIN: assert property (
        (!master_reset_pin_n) [*5] |-> device_reset)
        else $error("held reset pin gives no device reset");
    AST_NO_RST_ASLEEP: assert property (
        (power_down && master_reset_pin_n) [*3] |-> !device_reset)
        else $error("device reset while asleep without reset pin");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read cycle");

    COV_VECTOR: cover property (vector_take);
    COV_WAKE: cover property (wake_pulse);
    COV_RESET: cover property (device_reset && master_reset_pin_n);
endmodule : iswc_properties

bind iswc_core iswc_properties iswc_properties_inst (
    .ref_clk, .sys_rst, .reg_rd, .reg_rdata, .master_reset_pin_n,
    .sleep_instr, .vector_take, .vector_addr, .wake_pulse, .power_down,
    .device_reset
);
`default_nettype wire

//--- testbench/iswc_core_model.sv
// Behavioural model of the processor core that faces the control block.
`default_nettype none
module iswc_core_model (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Commands from the test sequence.
    input  wire logic       cmd_ret,
    input  wire logic       cmd_kick,
    input  wire logic       cmd_sleep,
    // Controls from the block.
    input  wire logic       vector_take,
    input  wire logic       wake_pulse,
    input  wire logic       power_down,
    input  wire logic       device_reset,
    // Instruction events to the block.
    output logic            irq_return_instr,
    output logic            watchdog_kick_instr,
    output logic            sleep_instr,
    // Event tallies.
    output logic      [7:0] n_vec,
    output logic      [7:0] n_wake,
    output logic      [7:0] n_rst
);
    // A halted core executes nothing, so commands are dropped while asleep.
    always_ff @(posedge ref_clk) begin
        irq_return_instr    <= cmd_ret & ~power_down;
        watchdog_kick_instr <= cmd_kick & ~power_down;
        sleep_instr         <= cmd_sleep & ~power_down;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            n_vec  <= 8'h00;
            n_wake <= 8'h00;
            n_rst  <= 8'h00;
        end else begin
            n_vec  <= n_vec + 8'(vector_take);
            n_wake <= n_wake + 8'(wake_pulse);
            n_rst  <= n_rst + 8'(device_reset);
        end
    end
endmodule : iswc_core_model
`default_nettype wire

//--- testbench/iswc_core_bench.sv
// Self-checking bench for the interrupt, sleep and watchdog control block.
`default_nettype none
module iswc_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] CTL = iswc_pkg::IRQ_CTRL_ADDR;
    localparam logic [13:0] OPT = iswc_pkg::OPTION_ADDR;
    localparam logic [13:0] STA = iswc_pkg::STATUS_ADDR;
    localparam logic [13:0] PF1 = iswc_pkg::PFLAG1_ADDR;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, ext_irq_pin, osc_en;
    logic        master_reset_pin_n, watchdog_osc_clk, vector_take;
    logic        irq_return_instr, watchdog_kick_instr, sleep_instr;
    logic        wake_pulse, power_down, device_reset;
    logic [3:0]  go, portb_high_pins;
    logic [13:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, n_vec, n_wake, n_rst;
    logic [12:0] vector_addr;
    logic [15:0] periph_event;
    int          fails, n_tests;

    iswc_core #(.WDT_BASE_W(3)) iswc_core_inst (
        .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ext_irq_pin, .portb_high_pins, .master_reset_pin_n,
        .watchdog_osc_clk, .timer_zero_overflow(go[0]), .periph_event,
        .irq_return_instr, .watchdog_kick_instr, .sleep_instr,
        .vector_take, .vector_addr, .wake_pulse, .power_down, .device_reset
    );
    iswc_core_model iswc_core_model_inst (
        .ref_clk, .sys_rst, .cmd_ret(go[1]), .cmd_kick(go[2]),
        .cmd_sleep(go[3]), .vector_take, .wake_pulse, .power_down,
        .device_reset, .irq_return_instr, .watchdog_kick_instr,
        .sleep_instr, .n_vec, .n_wake, .n_rst
    );

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rdc(input string w, input logic [13:0] a,
                       input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(w, reg_rdata, e);
    endtask : rdc

    // Bit 0 timer rollover, 1 return, 2 watchdog clear, 3 sleep.
    task automatic pulse(input int i);
        @(posedge ref_clk);
        go[i] <= 1'b1;
        @(posedge ref_clk);
        go <= 4'h0;
    endtask : pulse

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // The oscillator stands still unless a watchdog scenario runs it.
    initial begin
        watchdog_osc_clk = 1'b0;
        forever #75 if (osc_en) watchdog_osc_clk = ~watchdog_osc_clk;
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        fails++;
        end_sim();
    end

    initial begin
        {sys_rst, master_reset_pin_n} = 2'b11;
        {reg_wr, reg_rd, ext_irq_pin, osc_en, go} = 8'h00;
        {reg_addr, reg_wdata, portb_high_pins, periph_event} = '0;
        fails = 0;
        n_tests = 0;
        cyc(8);
        sys_rst <= 1'b0;
        rdc("control", CTL, 8'h00);
        rdc("option", OPT, 8'hff);
        rdc("status", STA, 8'h18);
        rdc("unmapped", 14'h0020, 8'h00);
        pulse(0);
        @(posedge ref_clk) periph_event <= 16'h0101;
        @(posedge ref_clk) periph_event <= 16'h0000;
        rdc("control", CTL, 8'h04);
        rdc("pflag1", PF1, 8'h01);
        rdc("pflag2", iswc_pkg::PFLAG2_ADDR, 8'h01);
        wr(CTL, 8'h00);
        wr(PF1, 8'h00);
        @(posedge ref_clk) portb_high_pins <= 4'h5;
        cyc(6);
        rdc("control", CTL, 8'h01);
        wr(CTL, 8'h00);
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        cyc(6);
        rdc("control", CTL, 8'h02);
        wr(OPT, 8'hb7);
        wr(CTL, 8'h00);
        @(posedge ref_clk) ext_irq_pin <= 1'b0;
        cyc(6);
        rdc("control", CTL, 8'h02);
        wr(CTL, 8'h90);
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        cyc(6);
        rdc("control", CTL, 8'h90);
        @(posedge ref_clk) ext_irq_pin <= 1'b0;
        cyc(16);
        chk("vectors", n_vec, 8'h01);
        chk("vector low", vector_addr[7:0], 8'h04);
        chk("vector high", {3'h0, vector_addr[12:8]}, 8'h00);
        rdc("control", CTL, 8'h12);
        wr(CTL, 8'h10);
        pulse(1);
        cyc(3);
        rdc("control", CTL, 8'h90);
        wr(iswc_pkg::PEN1_ADDR, 8'h01);
        @(posedge ref_clk) periph_event <= 16'h0001;
        @(posedge ref_clk) periph_event <= 16'h0000;
        cyc(12);
        chk("vectors", n_vec, 8'h01);
        wr(CTL, 8'hd0);
        cyc(12);
        chk("vectors", n_vec, 8'h02);
        wr(PF1, 8'h00);
        wr(CTL, 8'h10);
        pulse(3);
        cyc(3);
        chk("asleep", {7'h0, power_down}, 8'h01);
        rdc("status", STA, 8'h10);
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        cyc(8);
        @(posedge ref_clk) ext_irq_pin <= 1'b0;
        cyc(16);
        chk("wakes", n_wake, 8'h01);
        chk("vectors", n_vec, 8'h02);
        pulse(3);
        cyc(4);
        chk("asleep", {7'h0, power_down}, 8'h00);
        wr(CTL, 8'h90);
        pulse(3);
        cyc(3);
        @(posedge ref_clk) ext_irq_pin <= 1'b1;
        cyc(3);
        @(posedge ref_clk) ext_irq_pin <= 1'b0;
        cyc(20);
        chk("wakes", n_wake, 8'h02);
        chk("vectors", n_vec, 8'h03);
        wr(CTL, 8'h00);
        @(posedge ref_clk) osc_en <= 1'b1;
        cyc(80);
        osc_en <= 1'b0;
        chk("resets", n_rst, 8'h01);
        rdc("status", STA, 8'h08);
        rdc("option", OPT, 8'hff);
        wr(OPT, 8'hb7);
        pulse(3);
        cyc(3);
        osc_en <= 1'b1;
        cyc(80);
        osc_en <= 1'b0;
        chk("wakes", n_wake, 8'h03);
        chk("resets", n_rst, 8'h01);
        rdc("status", STA, 8'h00);
        repeat (6) begin
            pulse(2);
            osc_en <= 1'b1;
            cyc(15);
        end
        chk("resets", n_rst, 8'h01);
        wr(iswc_pkg::CONFIG_ADDR, 8'hfb);
        cyc(120);
        osc_en <= 1'b0;
        chk("resets", n_rst, 8'h01);
        wr(CTL, 8'h20);
        @(posedge ref_clk) master_reset_pin_n <= 1'b0;
        cyc(6);
        master_reset_pin_n <= 1'b1;
        cyc(6);
        rdc("control", CTL, 8'h00);
        rdc("option", OPT, 8'hff);
        end_sim();
    end
endmodule : iswc_core_bench
`default_nettype wire
